// ==== sar_pkg.sv ====
// Shared constants and types for the converter readout block
package sar_pkg;

  // Resolution
  localparam int SAR_BITS = 14;

  // Core clock and conversion window
  localparam int CLK_PERIOD_NS = 10;
  localparam int T_CONV_MIN_NS = 500;
  localparam int T_CONV_MAX_NS = 1600;
  localparam int CONV_MIN_CYC  = (T_CONV_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONV_MAX_CYC  = T_CONV_MAX_NS / CLK_PERIOD_NS;

  // Throughput limit and shortest cycle between strobes
  localparam int MAX_RATE_KSPS = 500;
  localparam int T_CYC_NS      = 1000000 / MAX_RATE_KSPS;

  // Cycles per bit decision, sized to land mid-window
  localparam int STEP_CYC = (CONV_MIN_CYC + CONV_MAX_CYC) / (2 * SAR_BITS);
  localparam logic [3:0] STEP_LAST = 4'(STEP_CYC - 1);

  // Code constants
  localparam logic [13:0] CODE_ZERO    = 14'h0000;
  localparam logic [13:0] CODE_FULL    = 14'h3fff;
  localparam logic [13:0] CODE_MSB     = 14'h2000;
  localparam logic [3:0]  BIT_MSB_IDX  = 4'hd;
  localparam logic [3:0]  BIT_LSB_IDX  = 4'h0;

  // Controller states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_CONV = 2'b10
  } sar_state_type;

  // Interface mode, coded as the serial input level at the strobe edge
  typedef enum logic {
    MODE_CHAIN  = 1'b0,
    MODE_SELECT = 1'b1
  } sar_mode_type;

  // Core-domain state
  typedef struct packed {
    sar_state_type state;
    sar_mode_type  mode;
    logic          cnv_m;
    logic          cnv_s;
    logic          cnv_d;
    logic          sdi_m;
    logic          sdi_s;
    logic [3:0]    step_cnt;
    logic [3:0]    bit_idx;
    logic [13:0]   trial;
    logic [13:0]   result;
    logic          gen;
    logic          busy_en;
    logic          oe;
  } sar_core_type;

  // Serial-clock-domain state
  typedef struct packed {
    logic        rst_m;
    logic        rst_s;
    logic        seen;
    logic [13:0] sh;
  } sar_link_type;

  localparam sar_core_type CORE_RST = '{
    state:    ST_IDLE,
    mode:     MODE_SELECT,
    cnv_m:    1'b0,
    cnv_s:    1'b0,
    cnv_d:    1'b0,
    sdi_m:    1'b1,
    sdi_s:    1'b1,
    step_cnt: 4'h0,
    bit_idx:  BIT_MSB_IDX,
    trial:    CODE_ZERO,
    result:   CODE_ZERO,
    gen:      1'b0,
    busy_en:  1'b0,
    oe:       1'b0
  };

endpackage

// ==== sar_readout.sv ====
// Conversion sequencer and serial result readout of the 14-bit converter
//
// Functional notes
// - Each strobe rising edge while idle starts a conversion and latches the interface mode.
// - Serial input low at strobe edge selects daisy-chain mode.
// - Serial input high at strobe edge selects select mode.
// - Select mode: output driver enabled while strobe or serial input low, else high impedance.
// - Select mode: output enabled while serial input or strobe is low.
// - Select mode: input or strobe low at conversion end enables busy indicator.
// - Chain mode: serial input is data, letting converters share one output.
// - Chain mode: serial input level reappears on output after 14 serial clocks.
// - Result bits leave serially, transitions aligned to the host serial clock.
// - Host supplies serial clocks while selected; one result bit per pulse.
// - Fourteen binary-weighted approximation steps, most significant bit decided first.
// - After decisions: back to acquisition, output code formed, busy signal raised in select mode only, with strobe or serial input low.
// - Conversion timed by internal clock, independent of serial clock activity.
// - Up to 500 kSPS; analog section powered down between conversions.
// - Result readable as soon as its conversion completes, no pipeline delay.
// - Result is a 14-bit straight binary serial word.
// - Result ready 0.5 to 1.6 us after strobe rise; host waits.
// - Overrange reads all ones 3fff, underrange reads all zeros 0000.
`timescale 1ns/1ps

module sar_readout
  import sar_pkg::*;
(
  // Core clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Host serial clock
  input  wire logic        serial_clk,
  // Host pins
  input  wire logic        convert_strobe,
  input  wire logic        serial_mode_in,
  output logic             serial_result_out,
  output logic             serial_result_oe,
  // Analog front end
  input  wire logic        comp_hi,
  output logic [13:0]      dac_code,
  output logic             sample_hold,
  output logic             analog_power_en
);

  sar_core_type core_r;
  sar_core_type core_nxt;
  sar_link_type link_r;
  sar_link_type link_nxt;

  logic cnv_rise;
  logic keep_bit;
  logic sel_low;
  logic fresh;

  // Strobe edge seen after the two-flop synchroniser
  assign cnv_rise = core_r.cnv_s & ~core_r.cnv_d;

  // Either select pin held low
  assign sel_low = ~core_r.cnv_s | ~core_r.sdi_s;

  // Comparator says input lies at or above the trial level
  assign keep_bit = comp_hi;

  // A finished result not yet touched by the serial clock
  assign fresh = core_r.gen ^ link_r.seen;

  // Core domain: pin sync, mode latch, successive approximation
  always_comb begin
    core_nxt = core_r;
    core_nxt.cnv_m = convert_strobe;
    core_nxt.cnv_s = core_r.cnv_m;
    core_nxt.cnv_d = core_r.cnv_s;
    core_nxt.sdi_m = serial_mode_in;
    core_nxt.sdi_s = core_r.sdi_m;

    case (core_r.state)
      ST_IDLE: begin
        if (cnv_rise) begin
          // Mode follows the serial input level at the strobe edge
          core_nxt.mode     = sar_mode_type'(core_r.sdi_s);
          core_nxt.state    = ST_CONV;
          core_nxt.bit_idx  = BIT_MSB_IDX;
          core_nxt.trial    = CODE_MSB;
          core_nxt.step_cnt = 4'h0;
          core_nxt.busy_en  = 1'b0;
        end
      end

      ST_CONV: begin
        // Steps paced by the core clock only
        core_nxt.step_cnt = core_r.step_cnt + 4'h1;
        if (core_r.step_cnt == STEP_LAST) begin
          core_nxt.step_cnt = 4'h0;
          // Drop the trial bit when the input sits below it
          if (!keep_bit) begin
            core_nxt.trial[core_r.bit_idx] = 1'b0;
          end
          if (core_r.bit_idx == BIT_LSB_IDX) begin
            // Last decision: publish and return to acquisition
            core_nxt.result  = core_nxt.trial;
            core_nxt.gen     = ~core_r.gen;
            core_nxt.state   = ST_IDLE;
            core_nxt.busy_en = (core_r.mode == MODE_SELECT) && sel_low;
          end else begin
            core_nxt.bit_idx = core_r.bit_idx - 4'h1;
            core_nxt.trial[core_r.bit_idx - 4'h1] = 1'b1;
          end
        end
      end

      default: begin
        core_nxt.state = ST_IDLE;
      end
    endcase

    // Output driver enable
    if (core_r.mode == MODE_SELECT) begin
      core_nxt.oe = sel_low;
    end else begin
      core_nxt.oe = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      core_r <= CORE_RST;
    end else begin
      core_r <= core_nxt;
    end
  end

  // Serial clock domain: result shifter and chain path.
  // Result and generation bit are held still from conversion end
  // until the next strobe, so the first falling edge loads them safely.
  always_comb begin
    link_nxt = link_r;
    link_nxt.rst_m = reset;
    link_nxt.rst_s = link_r.rst_m;
    if (link_r.rst_s) begin
      link_nxt.seen = 1'b0;
      link_nxt.sh   = CODE_ZERO;
    end else if (fresh) begin
      link_nxt.seen = core_r.gen;
      if (core_r.busy_en) begin
        // Busy high was shown first, so the word starts one edge later
        link_nxt.sh = core_r.result;
      end else begin
        // Most significant bit already shown; next bit moves up
        link_nxt.sh = {core_r.result[12:0], serial_mode_in};
      end
    end else begin
      // One bit per falling edge, chain data enters at the bottom
      link_nxt.sh = {link_r.sh[12:0], serial_mode_in};
    end
  end

  always_ff @(negedge serial_clk) begin
    link_r <= link_nxt;
  end

  // Serial output selection.
  // Only one of gen and seen moves at a time, so the pin does not glitch.
  always_comb begin
    if (core_r.state == ST_CONV) begin
      serial_result_out = 1'b0;
    end else if (fresh && core_r.busy_en) begin
      serial_result_out = 1'b1;
    end else if (fresh) begin
      serial_result_out = core_r.result[13];
    end else begin
      serial_result_out = link_r.sh[13];
    end
  end

  assign serial_result_oe = core_r.oe;

  // Analog front end controls
  assign dac_code        = core_r.trial;
  assign sample_hold     = (core_r.state == ST_CONV);
  assign analog_power_en = (core_r.state == ST_CONV);

endmodule

// ==== sar_readout_monitor.sv ====
// Port checker for the converter readout
`timescale 1ns/1ps
module sar_readout_monitor
  import sar_pkg::*;
(
  // Clocks and reset
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        serial_clk,
  // Host pins
  input wire logic        convert_strobe,
  input wire logic        serial_mode_in,
  input wire logic        serial_result_out,
  input wire logic        serial_result_oe,
  // Analog side
  input wire logic        comp_hi,
  input wire logic [13:0] dac_code,
  input wire logic        sample_hold,
  input wire logic        analog_power_en
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_conv_done;
    ##[47:157] $fell(sample_hold);
  endsequence
  a_start_hold: assert property (
    $rose(convert_strobe) && !sample_hold |-> ##[2:5] sample_hold) else $error("no start");
  a_conv_span: assert property (
    $rose(sample_hold) |-> s_conv_done) else $error("conversion length");
  a_power_tie: assert property (
    analog_power_en == sample_hold) else $error("power not tied to conversion");
  a_msb_trial: assert property (
    $rose(sample_hold) |-> dac_code == CODE_MSB) else $error("first trial not msb");
  a_trial_pace: assert property (
    $changed(dac_code) && sample_hold |=> (!sample_hold || $stable(dac_code))[*6])
    else $error("trial step too short");
  a_oe_enable: assert property (
    $fell(convert_strobe) && serial_mode_in |-> ##[1:5] serial_result_oe)
    else $error("output not enabled");
  a_busy_low: assert property (
    sample_hold && serial_result_oe |-> !serial_result_out) else $error("busy not low");
  a_ready_high: assert property (
    $fell(sample_hold) && !convert_strobe && serial_mode_in |-> ##[0:1] serial_result_out)
    else $error("ready not high");
endmodule

// ==== sar_host_model.sv ====
// Host controller model: strobe, mode pin and framed serial clock
`timescale 1ns/1ps
module sar_host_model (
  // Core clock for pin timing
  input wire logic clk,
  // Host pins
  output logic     convert_strobe,
  output logic     serial_mode_in,
  output logic     serial_clk,
  input wire logic serial_result_out
);
  initial begin
    convert_strobe = 1'b0;
    serial_mode_in = 1'b1;
    serial_clk = 1'b1;
  end
  task automatic pins(input logic strobe, input logic mode);
    @(posedge clk);
    #1;
    convert_strobe = strobe;
    serial_mode_in = mode;
  endtask
  // One frame of n clocks; bit taken before each falling edge
  task automatic xfer(input int n, input logic [13:0] din, output logic [27:0] dout);
    dout = '0;
    for (int k = 0; k < n; k++) begin
      dout = {dout[26:0], serial_result_out};
      if (k < 14) serial_mode_in = din[13-k];
      #20 serial_clk = 1'b0;
      #40 serial_clk = 1'b1;
      #20;
    end
  endtask
endmodule

// ==== test_sar_readout.sv ====
// Top-level testbench for the converter readout
`timescale 1ns/1ps
module test_sar_readout
  import sar_pkg::*;
;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic [13:0] vin = '0;
  logic        serial_clk, convert_strobe, serial_mode_in;
  logic        serial_result_out, serial_result_oe, sample_hold, analog_power_en;
  logic [13:0] dac_code;
  logic [27:0] rx;
  int          mismatches = 0;
  int          check_count = 0;
  wire         comp_hi = (vin >= dac_code);
  always #5 clk = ~clk;
  sar_host_model i_sar_host_model (.clk, .convert_strobe, .serial_mode_in, .serial_clk,
    .serial_result_out);
  sar_readout i_sar_readout (.clk, .reset, .serial_clk, .convert_strobe, .serial_mode_in,
    .serial_result_out, .serial_result_oe, .comp_hi, .dac_code, .sample_hold, .analog_power_en);
  task automatic check(input string what, input logic [27:0] exp, input logic [27:0] got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Select mode read, optionally with strobe low at the end of conversion
  task automatic t_select(input logic [13:0] code, input logic busy);
    vin = code;
    i_sar_host_model.pins(1'b0, 1'b1);
    i_sar_host_model.pins(1'b1, 1'b1);
    repeat (3) @(posedge clk);
    i_sar_host_model.pins(!busy, 1'b1);
    repeat (60) @(posedge clk);
    #1;
    if (busy) check("busy level", 28'h0, serial_result_out);
    repeat (60) @(posedge clk);
    #1;
    check("idle enable", busy, serial_result_oe);
    if (busy) check("ready level", 28'h1, serial_result_out);
    // Read under strobe low when busy, else under serial input low
    i_sar_host_model.pins(!busy, busy);
    repeat (5) @(posedge clk);
    #1;
    check("read enable", 28'h1, serial_result_oe);
    i_sar_host_model.xfer(14 + busy, {14{busy}}, rx);
    check("select word", busy ? {13'h0, 1'b1, code} : code, rx);
  endtask
  // Chain mode read: own result, then the serial input delayed by 14 clocks
  task automatic t_chain(input logic [13:0] code, input logic [13:0] din);
    vin = code;
    i_sar_host_model.pins(1'b0, 1'b0);
    i_sar_host_model.pins(1'b1, 1'b0);
    repeat (120) @(posedge clk);
    #1;
    check("chain enable", 28'h1, serial_result_oe);
    i_sar_host_model.xfer(28, din, rx);
    check("chain word", {code, din}, rx);
    i_sar_host_model.pins(1'b0, 1'b1);
  endtask
  initial begin
    fork
      i_sar_host_model.xfer(4, 14'h3fff, rx);
    join_none
    // Held longer so the serial side sees its reset edges
    repeat (30) @(posedge clk);
    #1 reset = 1'b0;
    t_select(14'h3fff, 1'b0);
    t_select(14'h0000, 1'b1);
    t_chain(14'h2001, 14'h1a5c);
    t_select(14'h1fff, 1'b1);
    t_chain(14'h0001, 14'h2c3a);
    wrap_up();
  end
  initial begin
    #50us;
    mismatches++;
    wrap_up();
  end
endmodule
bind sar_readout sar_readout_monitor i_sar_readout_monitor (.clk, .reset, .serial_clk,
  .convert_strobe,
  .serial_mode_in, .serial_result_out, .serial_result_oe, .comp_hi, .dac_code, .sample_hold,
  .analog_power_en);
